/* shared/macsr_pkg.sv */
// constants, types and register map of the motion axis configuration and status bank
// How it works
// - each filter enable bit passes its input group straight when 0, filtered when 1
// - enable bit 8 limits/stops 0-1, 9 stop 2, 10 servo, 11 ext drive, 12 inputs
// - emergency stop filtering follows only the X axis copy of bit 8
// - time constant code 0 rejects 1.75 us, codes 1-7 from 224 us doubling
// - filtered input is delayed 2 us for code 0, 256 us doubling for codes 1-7
// - filter/mode and interpolation mode registers clear to zero on reset
// - general output bits drive pins, bits 7-0 X axis, bits 15-8 Y axis
// - general output register clears on reset so every output pin is low
// - vector speed field: 00 off, 01 two-axis constant speed, 10/11 invalid
// - multichip field: 00 off, 01 main, 10 sub both axes, 11 sub X only
// - bit 12 steps by external pulse input, bit 13 steps by host command
// - bit 14 enables interpolation interrupt, bit 15 bit-pattern interrupt
// - command data low and high halves written in either order, bytes allowed
// - command data is binary with two's complement negatives at command length
// - circular finish point is 32-bit signed but only 24-bit signed span is valid
// - command data registers are not cleared by reset
// - axis error flag set when finished drive shows any finish error bit 15-12
// - axis error flag set when any error information bit 6-0 is 1
// - interpolation busy flag at bit 8 reads 1 while interpolation pulses run
// - bit 9 reads 1 when next node parameters and data may be written
// - bits 12-10 report the circular interpolation region 0 to 7
// - bits 14-13 report the bit-pattern stack counter during bit-pattern mode
// - stack counter 3 full, 2 one word free, 1 two free, 0 empty and done
package macsr_pkg;
  localparam logic [7:0]  ADR_FILT_X = 8'h00;
  localparam logic [7:0]  ADR_FILT_Y = 8'h04;
  localparam logic [7:0]  ADR_GOUT   = 8'h08;
  localparam logic [7:0]  ADR_MODE   = 8'h0c;
  localparam logic [7:0]  ADR_CMD_LO = 8'h10;
  localparam logic [7:0]  ADR_CMD_HI = 8'h14;
  localparam logic [7:0]  ADR_STATUS = 8'h18;
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [15:0] GOUT_RESET = 16'h0000;
  localparam logic        PIN_IDLE   = 1'b1;
  localparam int FILT_EN_LSB  = 8;
  localparam int FILT_TC_LSB  = 13;
  localparam int VSPD_LSB     = 8;
  localparam int ROLE_LSB     = 10;
  localparam int EXT_STEP_BIT = 12;
  localparam int CMD_STEP_BIT = 13;
  localparam int INTERP_IE    = 14;
  localparam int PATTERN_IE   = 15;
  localparam int ST_XDRIVE    = 0;
  localparam int ST_YDRIVE    = 1;
  localparam int ST_XERR      = 4;
  localparam int ST_YERR      = 5;
  localparam int ST_BUSY      = 8;
  localparam int ST_READY     = 9;
  localparam int ST_REGION    = 10;
  localparam int ST_STACK     = 13;
  localparam int NUM_PINS     = 15;
  localparam int CLOCK_MHZ    = 250;
  localparam int FILT_BASE_NS = 2000;
  localparam int FILT_STEP_NS = 256000;
  localparam int FILT_BASE_CYC = (FILT_BASE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int FILT_STEP_CYC = (FILT_STEP_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [2:0] FILT_GROUP [0:14] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2,
                                               3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};

  typedef enum logic [1:0] {
    ROLE_OFF    = 2'h0,
    ROLE_MAIN   = 2'h1,
    ROLE_SUB_XY = 2'h2,
    ROLE_SUB_X  = 2'h3
  } macsr_role_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } macsr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } macsr_wb_rsp_t;

  typedef struct packed {
    logic [5:0] general_input;
    logic       ext_drive_minus_in;
    logic       ext_drive_plus_in;
    logic       servo_alarm_in;
    logic       servo_in_position_in;
    logic       decel_stop_in_2;
    logic       decel_stop_in_1;
    logic       decel_stop_in_0;
    logic       minus_limit_in;
    logic       plus_limit_in;
  } macsr_axis_pins_t;

  typedef struct packed {
    logic [1:0] axis_drive_flag;
    logic [3:0] finish_err_x;
    logic [3:0] finish_err_y;
    logic [6:0] error_info_x;
    logic [6:0] error_info_y;
    logic       interp_busy_flag;
    logic       next_node_ready;
    logic       circular_active;
    logic [2:0] circle_region;
    logic       bitpattern_active;
    logic [1:0] stack_counter;
  } macsr_core_stat_t;

  typedef struct packed {
    logic [1:0]  vector_speed_mode;
    macsr_role_t multichip_role;
    logic        external_single_step_enable;
    logic        command_single_step_enable;
    logic        interp_interrupt_enable;
    logic        bitpattern_interrupt_enable;
  } macsr_mode_t;

  typedef struct packed {
    logic        level;
    logic [21:0] count;
  } macsr_filt_state_t;

  typedef struct packed {
    logic [30:0] sync1;
    logic [30:0] sync2;
    logic [15:0] filt_x;
    logic [15:0] filt_y;
    logic [15:0] gout;
    logic [15:0] mode;
    logic [31:0] cmd;
    logic        span;
    logic [15:0] status;
    logic        ack;
    logic [31:0] rdata;
  } macsr_top_state_t;
endpackage : macsr_pkg

/* src/macsr_regs.sv */
// input filters, configuration registers and main status word of the motion axis bank
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps

module macsr_filter (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        sample,
  input  wire logic        enable,
  input  wire logic [21:0] threshold,
  output logic             level
);
  import macsr_pkg::*;

  macsr_filt_state_t state;
  macsr_filt_state_t next_state;

  // a change is taken only after it has held for threshold cycles, so any
  // shorter pulse is dropped; the delay is the same for both edges
  always_comb begin
    next_state = state;
    if (clk_en) begin
      if (!enable || sample == state.level) begin
        next_state.level = sample;
        next_state.count = '0;
      end else if (state.count + 22'h1 >= threshold) begin
        next_state.level = sample;
        next_state.count = '0;
      end else begin
        next_state.count = state.count + 22'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state.level <= PIN_IDLE;
      state.count <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

  default clocking cb_f @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_pass;
    clk_en && !enable |=> level == $past(sample);
  endproperty
  a_pass: assert property (p_pass) else $error("filter bypass did not pass input");

  property p_hold;
    clk_en && enable && sample != level && (state.count + 22'h1 < threshold)
      |=> level == $past(level);
  endproperty
  a_hold: assert property (p_hold) else $error("filter let a short pulse through");

  property p_flip;
    clk_en && enable && sample != level && (state.count + 22'h1 >= threshold)
      |=> level == $past(sample) && state.count == 22'h0;
  endproperty
  a_flip: assert property (p_flip) else $error("filter missed a settled change");
endmodule : macsr_filter

module macsr_regs #(
  parameter int FILTER_STEP_CYCLES = macsr_pkg::FILT_STEP_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  input  wire macsr_pkg::macsr_wb_req_t    wb_req,
  output macsr_pkg::macsr_wb_rsp_t         wb_rsp,
  input  wire logic                    emergency_stop_in,
  input  wire macsr_pkg::macsr_axis_pins_t x_pins,
  input  wire macsr_pkg::macsr_axis_pins_t y_pins,
  input  wire macsr_pkg::macsr_core_stat_t core_stat,
  output logic                         emergency_filtered,
  output macsr_pkg::macsr_axis_pins_t      x_filtered,
  output macsr_pkg::macsr_axis_pins_t      y_filtered,
  output logic [15:0]                  x_filter_mode,
  output logic [15:0]                  y_filter_mode,
  output logic [15:0]                  general_output_pins,
  output macsr_pkg::macsr_mode_t           interp_mode,
  output logic signed [31:0]           command_data_word,
  output logic                         cmd_in_circle_span,
  output logic [15:0]                  main_status_word
);
  import macsr_pkg::*;

  macsr_top_state_t  state;
  macsr_top_state_t  next_state;
  logic [1:0][4:0]   filter_enable_bits;
  logic [1:0][21:0]  thr;
  logic [30:0]       filtered;
  logic              hit;
  logic [7:0]        word_adr;
  logic [15:0]       merged;
  logic [31:0]       rd;
  logic [15:0]       st;

  // code 0 waits the short base time, codes 1 to 7 double from the step time
  function automatic logic [21:0] tc_cycles(input logic [2:0] code);
    if (code == 3'h0) begin
      return 22'(FILT_BASE_CYC);
    end
    return 22'(FILTER_STEP_CYCLES) << (code - 3'h1);
  endfunction : tc_cycles

  // byte lanes let a narrow host fill a half word one byte at a time
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] dat,
                                         input logic [1:0] sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : lane16

  assign filter_enable_bits[0] = state.filt_x[FILT_EN_LSB +: 5];
  assign filter_enable_bits[1] = state.filt_y[FILT_EN_LSB +: 5];
  assign thr[0] = tc_cycles(state.filt_x[FILT_TC_LSB +: 3]);
  assign thr[1] = tc_cycles(state.filt_y[FILT_TC_LSB +: 3]);

  // emergency stop is shared by both axes and is steered by the X copy only
  for (genvar i = 0; i < 31; i++) begin : g_filt
    localparam int AX = (i >= NUM_PINS && i < 2 * NUM_PINS) ? 1 : 0;
    localparam int GI = (i == 2 * NUM_PINS) ? 0 : int'(FILT_GROUP[i % NUM_PINS]);
    macsr_filter u_filt (
      .clock     (clock),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .sample    (state.sync2[i]),
      .enable    (filter_enable_bits[AX][GI]),
      .threshold (thr[AX]),
      .level     (filtered[i])
    );
  end

  assign word_adr = {wb_req.adr[7:2], 2'b00};
  assign hit = wb_req.cyc && wb_req.stb;

  // write-only registers read back for software convenience
  always_comb begin
    case (word_adr)
      ADR_FILT_X: rd = {16'h0000, state.filt_x};
      ADR_FILT_Y: rd = {16'h0000, state.filt_y};
      ADR_GOUT:   rd = {16'h0000, state.gout};
      ADR_MODE:   rd = {16'h0000, state.mode};
      ADR_CMD_LO: rd = {16'h0000, state.cmd[15:0]};
      ADR_CMD_HI: rd = {16'h0000, state.cmd[31:16]};
      ADR_STATUS: rd = {16'h0000, state.status};
      default:    rd = 32'h00000000;
    endcase
  end

  always_comb begin
    next_state = state;
    merged = 16'h0000;
    st = 16'h0000;
    if (clk_en) begin
      next_state.sync1 = {emergency_stop_in, y_pins, x_pins};
      next_state.sync2 = state.sync1;
      // ack comes one edge after the request; it drops again the next edge
      next_state.ack = hit && !state.ack;
      next_state.rdata = (hit && !state.ack) ? rd : 32'h00000000;
      if (hit && state.ack && wb_req.we) begin
        case (word_adr)
          ADR_FILT_X: next_state.filt_x = lane16(state.filt_x, wb_req.dat[15:0], wb_req.sel[1:0]);
          ADR_FILT_Y: next_state.filt_y = lane16(state.filt_y, wb_req.dat[15:0], wb_req.sel[1:0]);
          ADR_GOUT:   next_state.gout = lane16(state.gout, wb_req.dat[15:0], wb_req.sel[1:0]);
          ADR_MODE: begin
            merged = lane16(state.mode, wb_req.dat[15:0], wb_req.sel[1:0]);
            // codes 10 and 11 are not usable, they fall back to off
            if (merged[VSPD_LSB + 1]) begin
              merged[VSPD_LSB +: 2] = 2'b00;
            end
            next_state.mode = merged;
          end
          ADR_CMD_LO: begin
            next_state.cmd[15:0] = lane16(state.cmd[15:0], wb_req.dat[15:0],
                                          wb_req.sel[1:0]);
          end
          ADR_CMD_HI: begin
            next_state.cmd[31:16] = lane16(state.cmd[31:16], wb_req.dat[15:0],
                                           wb_req.sel[1:0]);
          end
          default: begin
          end
        endcase
      end
      // a value fits the circular span when bits 31 to 23 all agree
      next_state.span = (&next_state.cmd[31:23]) || !(|next_state.cmd[31:23]);
      st[ST_XDRIVE] = core_stat.axis_drive_flag[0];
      st[ST_YDRIVE] = core_stat.axis_drive_flag[1];
      st[ST_XERR] = (!core_stat.axis_drive_flag[0] && (|core_stat.finish_err_x))
                    || (|core_stat.error_info_x);
      st[ST_YERR] = (!core_stat.axis_drive_flag[1] && (|core_stat.finish_err_y))
                    || (|core_stat.error_info_y);
      st[ST_BUSY] = core_stat.interp_busy_flag;
      st[ST_READY] = core_stat.next_node_ready;
      if (core_stat.circular_active) begin
        st[ST_REGION +: 3] = core_stat.circle_region;
      end
      // 3 full, 2 and 1 show free words, 0 empty and finished
      if (core_stat.bitpattern_active) begin
        st[ST_STACK +: 2] = core_stat.stack_counter;
      end
      next_state.status = st;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state.sync1 <= {31{PIN_IDLE}};
      state.sync2 <= {31{PIN_IDLE}};
      state.filt_x <= CFG_RESET;
      state.filt_y <= CFG_RESET;
      state.gout <= GOUT_RESET;
      state.mode <= CFG_RESET;
      state.cmd <= state.cmd;
      state.span <= 1'b0;
      state.status <= 16'h0000;
      state.ack <= 1'b0;
      state.rdata <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  assign wb_rsp.ack = state.ack;
  assign wb_rsp.dat = state.rdata;
  assign x_filtered = filtered[14:0];
  assign y_filtered = filtered[29:15];
  assign emergency_filtered = filtered[30];
  assign x_filter_mode = state.filt_x;
  assign y_filter_mode = state.filt_y;
  assign general_output_pins = state.gout;
  assign interp_mode.vector_speed_mode = state.mode[VSPD_LSB +: 2];
  assign interp_mode.multichip_role = macsr_role_t'(state.mode[ROLE_LSB +: 2]);
  assign interp_mode.external_single_step_enable = state.mode[EXT_STEP_BIT];
  assign interp_mode.command_single_step_enable = state.mode[CMD_STEP_BIT];
  assign interp_mode.interp_interrupt_enable = state.mode[INTERP_IE];
  assign interp_mode.bitpattern_interrupt_enable = state.mode[PATTERN_IE];
  // raw two's complement; each command reads the length it needs
  assign command_data_word = state.cmd;
  assign cmd_in_circle_span = state.span;
  assign main_status_word = state.status;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_reset;
    disable iff (1'b0)
    !reset_n |=> x_filter_mode == 16'h0000 && y_filter_mode == 16'h0000
                 && interp_mode == '0 && general_output_pins == 16'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("registers not cleared by reset");

  property p_gout;
    clk_en && wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.we && word_adr == ADR_GOUT
      && wb_req.sel[1:0] == 2'b11 |=> general_output_pins == $past(wb_req.dat[15:0]);
  endproperty
  a_gout: assert property (p_gout) else $error("output pins do not follow write");

  property p_vspd;
    interp_mode.vector_speed_mode[1] == 1'b0;
  endproperty
  a_vspd: assert property (p_vspd) else $error("invalid vector speed code stored");

  property p_tc0;
    clk_en && wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.we && word_adr == ADR_FILT_X
      && wb_req.sel[1] && wb_req.dat[15:13] == 3'h0 |=> thr[0] == 22'd500;
  endproperty
  a_tc0: assert property (p_tc0) else $error("code 0 filter delay is not 2 us");

  property p_drive;
    clk_en |=> main_status_word[1:0] == $past(core_stat.axis_drive_flag);
  endproperty
  a_drive: assert property (p_drive) else $error("drive flags do not follow axes");

  property p_fin_err;
    clk_en && !core_stat.axis_drive_flag[0] && (|core_stat.finish_err_x)
      |=> main_status_word[ST_XERR];
  endproperty
  a_fin_err: assert property (p_fin_err) else $error("finish error not flagged");

  property p_info_err;
    clk_en && (|core_stat.error_info_y) |=> main_status_word[ST_YERR];
  endproperty
  a_info_err: assert property (p_info_err) else $error("error info not flagged");

  property p_region;
    clk_en |=> main_status_word[12:10] ==
               ($past(core_stat.circular_active) ? $past(core_stat.circle_region) : 3'h0);
  endproperty
  a_region: assert property (p_region) else $error("circle region field wrong");

  property p_stack;
    clk_en && !core_stat.bitpattern_active |=> main_status_word[14:13] == 2'b00;
  endproperty
  a_stack: assert property (p_stack) else $error("stack count outside pattern mode");

  property p_unused;
    main_status_word[15] == 1'b0 && main_status_word[7:6] == 2'b00
      && main_status_word[3:2] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
endmodule : macsr_regs

/* dv/macsr_host.sv */
// host cpu model: classic wishbone master driving the register bank
`timescale 1ns/10ps
module macsr_host (
  input  wire logic              clock,
  output macsr_pkg::macsr_wb_req_t wb_req,
  input  wire macsr_pkg::macsr_wb_rsp_t wb_rsp
);
  import macsr_pkg::*;
  initial wb_req = '0;
  // one 16-bit half per access; command data is sent as two halves
  // software keeps finish points in the signed 24-bit span unless a test says otherwise
  // vector range ratio is software's business, no register here holds it
  // no cycle budget here: only the bench timeout may end a wait for ack
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge clock);
    wb_req.cyc <= 1'b1;
    wb_req.stb <= 1'b1;
    wb_req.we  <= we;
    wb_req.adr <= adr;
    wb_req.sel <= sel;
    wb_req.dat <= wdat;
    do begin
      @(posedge clock);
    end while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    wb_req.we  <= 1'b0;
    // a released data bus must not keep showing the last value
    wb_req.dat <= ~wdat;
  endtask : xfer
endmodule : macsr_host

/* dv/tb_macsr_regs.sv */
// self-checking bench for the motion axis configuration and status bank
`timescale 1ns/10ps
module tb_macsr_regs;
  import macsr_pkg::*;
  localparam int STEP = 8;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  macsr_wb_req_t wb_req;
  macsr_wb_rsp_t wb_rsp;
  logic emergency_stop_in = 1'b1;
  macsr_axis_pins_t x_pins = '1;
  macsr_axis_pins_t y_pins = '1;
  macsr_core_stat_t core_stat = '0;
  logic emergency_filtered;
  macsr_axis_pins_t x_filtered;
  macsr_axis_pins_t y_filtered;
  logic [15:0] x_filter_mode;
  logic [15:0] y_filter_mode;
  logic [15:0] general_output_pins;
  macsr_mode_t interp_mode;
  logic signed [31:0] command_data_word;
  logic cmd_in_circle_span;
  logic [15:0] main_status_word;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 78;
  logic [15:0] model [0:7];
  logic [31:0] rd;
  logic [63:0] rnd;
  macsr_core_stat_t cs;
  int cv [0:5] = '{8388607, 8388608, -8388608, -8388609, 0, -1};
  int n;
  int cnt;
  logic hit;

  always #2 clock = ~clock;

  macsr_host host_u (.clock(clock), .wb_req(wb_req), .wb_rsp(wb_rsp));

  macsr_regs #(.FILTER_STEP_CYCLES(STEP)) dut_u (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .emergency_stop_in(emergency_stop_in), .x_pins(x_pins), .y_pins(y_pins),
    .core_stat(core_stat), .emergency_filtered(emergency_filtered),
    .x_filtered(x_filtered), .y_filtered(y_filtered), .x_filter_mode(x_filter_mode),
    .y_filter_mode(y_filter_mode), .general_output_pins(general_output_pins),
    .interp_mode(interp_mode), .command_data_word(command_data_word),
    .cmd_in_circle_span(cmd_in_circle_span), .main_status_word(main_status_word));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // shadow update mirrors the bank: status ignored, bad vector speed codes stored as 00
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == ADR_MODE && v[9]) v[9:8] = 2'h0;
    host_u.xfer(1'b1, a, 4'h3, {16'h0, d}, rd);
    if (a != ADR_STATUS) model[a[4:2]] = v;
    @(negedge clock);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    host_u.xfer(1'b0, a, 4'h3, 32'h0, rd);
    chk(what, rd, exp);
  endtask : rdchk

  function automatic int grp(input int i);
    return (i < 4) ? 0 : (i == 4) ? 1 : (i < 7) ? 2 : (i < 9) ? 3 : 4;
  endfunction : grp

  function automatic logic [15:0] st_exp(input macsr_core_stat_t c);
    logic [15:0] s;
    s = 16'h0000;
    s[1:0] = c.axis_drive_flag;
    s[4] = (!c.axis_drive_flag[0] && |c.finish_err_x) || |c.error_info_x;
    s[5] = (!c.axis_drive_flag[1] && |c.finish_err_y) || |c.error_info_y;
    s[8] = c.interp_busy_flag;
    s[9] = c.next_node_ready;
    if (c.circular_active) s[12:10] = c.circle_region;
    if (c.bitpattern_active) s[14:13] = c.stack_counter;
    return s;
  endfunction : st_exp

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("filter x reg", {16'h0, x_filter_mode}, 32'h0);
    chk("mode reg", {24'h0, interp_mode}, 32'h0);
    chk("gout pins", {16'h0, general_output_pins}, 32'h0);
    rdchk(ADR_FILT_Y, 32'h0, "rd filter y");
    rdchk(ADR_MODE, 32'h0, "rd mode");
    $display("test reset done");
    repeat (8) begin
      rnd = {$random(seed), $random(seed)};
      wr(ADR_GOUT, rnd[15:0]);
      chk("gout pins", {16'h0, general_output_pins}, {16'h0, rnd[15:0]});
      rdchk(ADR_GOUT, {16'h0, model[2]}, "rd gout");
    end
    for (int c = 0; c < 16; c++) begin
      rnd = {$random(seed), $random(seed)};
      wr(ADR_MODE, {rnd[15:12], c[3:2], c[1:0], rnd[7:0]});
      rd = {24'h0, model[3][9:8], model[3][11:10], model[3][12], model[3][13],
            model[3][14], model[3][15]};
      chk("mode fields", {24'h0, interp_mode}, rd);
      rdchk(ADR_MODE, {16'h0, model[3]}, "rd mode");
    end
    $display("test config registers done");
    for (int i = 0; i < 6; i++) begin
      if (i % 2) begin
        wr(ADR_CMD_LO, cv[i][15:0]);
        wr(ADR_CMD_HI, cv[i][31:16]);
      end else begin
        wr(ADR_CMD_HI, cv[i][31:16]);
        wr(ADR_CMD_LO, cv[i][15:0]);
      end
      chk("command word", command_data_word, cv[i]);
      chk("circle span", {31'h0, cmd_in_circle_span},
          {31'h0, (cv[i] >= -8388608 && cv[i] <= 8388607)});
      rdchk(ADR_CMD_HI, {16'h0, model[5]}, "rd command high");
    end
    // a byte-wide host fills the halves one lane at a time, other lanes hold junk
    host_u.xfer(1'b1, ADR_CMD_HI, 4'h2, 32'h000012ab, rd);
    host_u.xfer(1'b1, ADR_CMD_LO, 4'h1, 32'h0000cd34, rd);
    host_u.xfer(1'b1, ADR_CMD_HI, 4'h1, 32'h0000ef56, rd);
    host_u.xfer(1'b1, ADR_CMD_LO, 4'h2, 32'h00007899, rd);
    @(negedge clock);
    chk("byte lanes", command_data_word, 32'h12567834);
    wr(ADR_STATUS, 16'hffff);
    rdchk(8'h1c, 32'h0, "rd unmapped");
    $display("test command data done");
    repeat (24) begin
      rnd = {$random(seed), $random(seed)};
      cs = rnd[32:0];
      @(posedge clock);
      core_stat <= cs;
      @(posedge clock);
      @(negedge clock);
      rd = {16'h0, st_exp(cs)};
      chk("status drive", main_status_word[1:0], rd[1:0]);
      chk("status errors", main_status_word[5:4], rd[5:4]);
      chk("status interp", main_status_word[9:8], rd[9:8]);
      chk("status region", main_status_word[12:10], rd[12:10]);
      chk("status stack", main_status_word[14:13], rd[14:13]);
      chk("status word", {16'h0, main_status_word}, rd);
    end
    rdchk(ADR_STATUS, {16'h0, st_exp(cs)}, "rd status");
    // with the enable low the status word must not follow the core
    @(posedge clock);
    clk_en <= 1'b0;
    core_stat <= ~cs;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("status frozen", {16'h0, main_status_word}, {16'h0, st_exp(cs)});
    @(posedge clock);
    clk_en <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("status thawed", {16'h0, main_status_word}, {16'h0, st_exp(~cs)});
    $display("test status done");
    for (int g = 0; g < 5; g++) begin
      wr(ADR_FILT_X, 16'h2000 | (16'h0100 << g));
      for (int i = 0; i < 16; i++) begin
        @(posedge clock);
        if (i < 15) x_pins[i] <= 1'b0;
        else emergency_stop_in <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        if (i < 15) chk("group pin", {31'h0, x_filtered[i]}, {31'h0, grp(i) == g});
        else chk("group emergency", {31'h0, emergency_filtered}, {31'h0, g == 0});
        @(posedge clock);
        x_pins <= '1;
        emergency_stop_in <= 1'b1;
        repeat (STEP + 6) @(posedge clock);
      end
    end
    $display("test filter groups done");
    for (int k = 0; k < 8; k++) begin
      wr(ADR_FILT_X, {k[2:0], 5'h1f, 8'h00});
      n = (k == 0) ? 500 : (STEP << (k - 1));
      @(posedge clock);
      x_pins[0] <= 1'b0;
      cnt = 0;
      while (cnt < n + 10 && x_filtered[0] !== 1'b0) begin
        @(negedge clock);
        cnt++;
      end
      chk("delay not short", {31'h0, cnt >= n}, 32'h1);
      chk("delay not long", {31'h0, cnt <= n + 4}, 32'h1);
      @(posedge clock);
      x_pins[0] <= 1'b1;
      repeat (n + 8) @(posedge clock);
      x_pins[0] <= 1'b0;
      repeat (n / 2) @(posedge clock);
      x_pins[0] <= 1'b1;
      hit = 1'b0;
      repeat (n + 8) begin
        @(negedge clock);
        if (x_filtered[0] !== 1'b1) hit = 1'b1;
      end
      chk("short pulse lost", {31'h0, hit}, 32'h0);
    end
    $display("test filter time constants done");
    wr(ADR_FILT_X, 16'h0000);
    wr(ADR_FILT_Y, 16'h3f00);
    chk("filter y reg", {16'h0, y_filter_mode}, 32'h3f00);
    @(posedge clock);
    emergency_stop_in <= 1'b0;
    y_pins[0] <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("emergency from x copy", {31'h0, emergency_filtered}, 32'h0);
    chk("y pin filtered", {31'h0, y_filtered[0]}, 32'h1);
    rdchk(ADR_FILT_Y, 32'h3f00, "rd filter y");
    $display("test emergency source done");
    wr(ADR_GOUT, 16'h5a3c);
    wr(ADR_MODE, 16'hf5ff);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk("gout after reset", {16'h0, general_output_pins}, {16'h0, GOUT_RESET});
    chk("filter y after reset", {16'h0, y_filter_mode}, {16'h0, CFG_RESET});
    chk("mode after reset", {24'h0, interp_mode}, 32'h0);
    chk("command kept", command_data_word, 32'h12567834);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb_macsr_regs
